// ===== src/sdb_status_ctrl.sv
// Operation
// - background enable stays set until reset
// - enable clear refuses halt, other commands work
// - background active bit read-only, shows halt
// - breakpoint disabled ignores select and address
// - force match halts at next instruction boundary
// - tag match marks opcode, halts at queue end
// - clock select resets to alternate source
// - wait stop status during or after wait
// - halt command wakes cpu from wait/stop
// - failed memory access during wait sets failure
// - data valid failure always reads zero
// - status byte only via query and store
// - 16-bit match address via dedicated commands
// - store ignores the four status bits
// - enable write blocked while halted
`timescale 1ns/1ns
`default_nettype none
`include "sdb_params.svh"

module sdb_status_ctrl (
    // clock and reset
    input  wire logic              CLK,
    input  wire logic              RESETN,
    // decoded serial commands
    input  wire logic              CMD_VALID,
    input  wire sdb_pkg::sdb_cmd_type  CMD_CODE,
    input  wire sdb_pkg::sdb_word_type CMD_DATA,
    // command answers
    output logic                   RSP_VALID,
    output sdb_pkg::sdb_word_type  RSP_DATA,
    output logic                   MEM_GRANT,
    output logic                   MEM_FAIL,
    // cpu bus and mode
    input  wire sdb_pkg::sdb_word_type CPU_ADDR,
    input  wire logic              CPU_BUS_VALID,
    input  wire logic              CPU_OPFETCH,
    input  wire logic              CPU_BOUNDARY,
    input  wire logic              CPU_TAG_AT_END,
    input  wire logic              CPU_WAIT_STOP,
    input  wire logic              CPU_WS_EXEC,
    // controls toward cpu and link
    output logic                   CPU_HALT,
    output logic                   TAG_MARK,
    output logic                   SOFT_INT_REQ,
    output logic                   COMM_CLK_SEL
);
    import sdb_pkg::*;

    // true when a valid command of the given code is present
    function automatic logic is_cmd(input logic valid,
                                    input sdb_cmd_type code,
                                    input sdb_cmd_type want);
        is_cmd = valid && (code == want);
    endfunction

    sdb_ctrl_state_type st_q;       // registered state
    sdb_ctrl_state_type st_d;       // next state
    logic               c_status;   // status query this cycle
    logic               c_control;  // control store this cycle
    logic               c_mfetch;   // match fetch this cycle
    logic               c_mload;    // match load this cycle
    logic               c_halt;     // halt command this cycle
    logic               c_resume;   // resume command this cycle
    logic               c_memacc;   // memory access command
    logic               ws_cond;    // cpu in or entering wait/stop
    logic               force_take; // pending force meets boundary
    logic               brk_event;  // any breakpoint halt request
    logic               mem_bad;    // memory access collides
    logic [15:0]        match_addr; // stored breakpoint address
    logic               tag_hit;    // registered tag match
    logic               force_hit;  // registered force match
    logic               fpend_q;    // force waiting for boundary
    logic               wsf_q;      // wait/stop failure flag
    logic [7:0]         status_b;   // byte returned by a query

    // command decode, only dedicated commands reach the registers
    assign c_status  = is_cmd(CMD_VALID, CMD_CODE, `SDB_CMD_STATUS);
    assign c_control = is_cmd(CMD_VALID, CMD_CODE, `SDB_CMD_CONTROL);
    assign c_mfetch  = is_cmd(CMD_VALID, CMD_CODE, `SDB_CMD_MFETCH);
    assign c_mload   = is_cmd(CMD_VALID, CMD_CODE, `SDB_CMD_MLOAD);
    assign c_halt    = is_cmd(CMD_VALID, CMD_CODE, `SDB_CMD_HALT);
    assign c_resume  = is_cmd(CMD_VALID, CMD_CODE, `SDB_CMD_RESUME);
    assign c_memacc  = is_cmd(CMD_VALID, CMD_CODE, `SDB_CMD_MEMACC);

    // wait/stop seen now or an instruction about to enter it
    assign ws_cond = CPU_WAIT_STOP || CPU_WS_EXEC;

    // halted cpu runs no wait/stop, so accesses cannot collide
    assign mem_bad = c_memacc && ws_cond && (st_q.mode == SDB_RUN);

    // force halt waits for the next instruction boundary
    assign force_take = fpend_q && CPU_BOUNDARY && st_q.bkpt_en;

    // tagged opcode at queue end or force boundary
    assign brk_event = force_take || (CPU_TAG_AT_END && st_q.bkpt_en);

    // status byte, data valid failure hard wired low
    always_comb begin
        status_b = 8'h00;
        status_b[`SDB_BIT_BG_ENABLE]  = st_q.bg_enable;
        status_b[`SDB_BIT_BG_ACTIVE]  = st_q.bg_active;
        status_b[`SDB_BIT_BKPT_EN]    = st_q.bkpt_en;
        status_b[`SDB_BIT_FORCE_SEL]  = st_q.force_sel;
        status_b[`SDB_BIT_CLK_SEL]    = st_q.clk_sel;
        status_b[`SDB_BIT_WS_STATUS]  = st_q.ws_status;
        status_b[`SDB_BIT_WS_FAILURE] = wsf_q;
        status_b[`SDB_BIT_DV_FAILURE] = 1'b0;
    end

    // breakpoint register and comparator
    sdb_bkpt u_bkpt (
        .clk        (CLK),
        .resetn     (RESETN),
        .load       (c_mload),
        .load_data  (CMD_DATA),
        .addr       (CPU_ADDR),
        .bus_valid  (CPU_BUS_VALID),
        .op_fetch   (CPU_OPFETCH),
        .tag_en     (st_q.bkpt_en && !st_q.force_sel),
        .force_en   (st_q.bkpt_en && st_q.force_sel),
        .match_addr (match_addr),
        .tag_hit    (tag_hit),
        .force_hit  (force_hit)
    );

    // force match held until the boundary, dropped when disabled
    sdb_flag u_fpend (
        .clk    (CLK),
        .resetn (RESETN),
        .set    (force_hit),
        .clr    (force_take || !st_q.bkpt_en),
        .q      (fpend_q)
    );

    // failure sticks until an access goes through cleanly
    sdb_flag u_wsf (
        .clk    (CLK),
        .resetn (RESETN),
        .set    (mem_bad),
        .clr    (c_memacc && !mem_bad),
        .q      (wsf_q)
    );

    // next-state logic for modes, control byte and answers
    always_comb begin
        st_d = st_q;
        // one-cycle answers fall back each cycle
        st_d.rsp_valid = 1'b0;
        st_d.mem_grant = 1'b0;
        st_d.mem_fail  = 1'b0;
        st_d.soft_req  = 1'b0;

        // control store, status bits are never taken from data
        if (c_control) begin
            // enable may only rise, and not while halted
            if ((st_q.mode == SDB_RUN) && CMD_DATA[`SDB_BIT_BG_ENABLE]) begin
                st_d.bg_enable = 1'b1;
            end
            st_d.bkpt_en   = CMD_DATA[`SDB_BIT_BKPT_EN];
            st_d.force_sel = CMD_DATA[`SDB_BIT_FORCE_SEL];
            st_d.clk_sel   = CMD_DATA[`SDB_BIT_CLK_SEL];
        end

        // answers to status query and match fetch
        if (c_status) begin
            st_d.rsp_valid = 1'b1;
            st_d.rsp_data  = {8'h00, status_b};
        end else if (c_mfetch) begin
            st_d.rsp_valid = 1'b1;
            st_d.rsp_data  = match_addr;
        end

        // memory access outcome, non-intrusive so always tried
        if (c_memacc) begin
            st_d.mem_fail  = mem_bad;
            st_d.mem_grant = !mem_bad;
        end

        // halted-mode sequencing
        case (st_q.mode)
            SDB_RUN: begin
                if (st_q.bg_enable && (c_halt || brk_event)) begin
                    // halt command also pulls cpu out of wait/stop
                    st_d.mode     = SDB_HALTED;
                    st_d.ws_latch = c_halt && CPU_WAIT_STOP;
                end else if (brk_event) begin
                    // not permitted, cpu takes a software interrupt
                    st_d.soft_req = 1'b1;
                end
            end
            SDB_HALTED: begin
                if (c_resume) begin
                    st_d.mode     = SDB_RUN;
                    st_d.ws_latch = 1'b0;
                end
            end
            default: begin
                st_d.mode = SDB_RUN;
            end
        endcase

        // output copies of the next mode and wait/stop status
        st_d.bg_active = (st_d.mode == SDB_HALTED);
        st_d.ws_status = ((st_d.mode == SDB_RUN) && CPU_WAIT_STOP)
                         || st_d.ws_latch;
    end

    // synchronous active-low reset; clears the enable too
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            st_q.mode      <= SDB_RUN;
            st_q.bg_active <= 1'b0;
            st_q.bg_enable <= `SDB_CTL_RESET;
            st_q.bkpt_en   <= `SDB_CTL_RESET;
            st_q.force_sel <= `SDB_CTL_RESET;
            st_q.clk_sel   <= `SDB_CTL_RESET;
            st_q.ws_latch  <= 1'b0;
            st_q.ws_status <= 1'b0;
            st_q.rsp_valid <= 1'b0;
            st_q.rsp_data  <= `SDB_RSP_RESET;
            st_q.mem_grant <= 1'b0;
            st_q.mem_fail  <= 1'b0;
            st_q.soft_req  <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // every output straight from a flip-flop
    assign RSP_VALID    = st_q.rsp_valid;
    assign RSP_DATA     = st_q.rsp_data;
    assign MEM_GRANT    = st_q.mem_grant;
    assign MEM_FAIL     = st_q.mem_fail;
    assign CPU_HALT     = st_q.bg_active;
    assign TAG_MARK     = tag_hit;
    assign SOFT_INT_REQ = st_q.soft_req;
    assign COMM_CLK_SEL = st_q.clk_sel;

    // checks, all on CLK with reset as disable
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    // halt command seen while running with enable set
    sequence s_halt_ok;
        c_halt && st_q.bg_enable && (st_q.mode == SDB_RUN);
    endsequence

    property p_enable_sticky;
        $past(RESETN) |-> !$fell(st_q.bg_enable);
    endproperty
    a_enable_sticky: assert property (p_enable_sticky)
        else $error("background enable dropped without reset");

    property p_refuse_halt;
        c_halt && !st_q.bg_enable && !CPU_HALT |=> !CPU_HALT;
    endproperty
    a_refuse_halt: assert property (p_refuse_halt)
        else $error("halt entered while not permitted");

    property p_active_readback;
        c_status |=> RSP_VALID && (RSP_DATA[`SDB_BIT_BG_ACTIVE] == $past(CPU_HALT));
    endproperty
    a_active_readback: assert property (p_active_readback)
        else $error("active bit does not show halt state");

    property p_bkpt_off;
        !st_q.bkpt_en |=> !TAG_MARK && !force_hit;
    endproperty
    a_bkpt_off: assert property (p_bkpt_off)
        else $error("disabled breakpoint produced a match");

    property p_force_halt;
        force_take && st_q.bg_enable && (st_q.mode == SDB_RUN) |=> CPU_HALT;
    endproperty
    a_force_halt: assert property (p_force_halt)
        else $error("force match did not halt at boundary");

    property p_tag_mark;
        CPU_OPFETCH && (CPU_ADDR == match_addr) && st_q.bkpt_en && !st_q.force_sel
            |=> TAG_MARK;
    endproperty
    a_tag_mark: assert property (p_tag_mark)
        else $error("matching fetch not tagged");

    property p_clk_default;
        $rose(RESETN) |-> !COMM_CLK_SEL;
    endproperty
    a_clk_default: assert property (p_clk_default)
        else $error("clock select not zero after reset");

    property p_ws_status;
        CPU_WAIT_STOP && !CPU_HALT && !c_halt |=> st_q.ws_status;
    endproperty
    a_ws_status: assert property (p_ws_status)
        else $error("wait stop status missing");

    property p_wake_halt;
        s_halt_ok ##0 CPU_WAIT_STOP |=> (CPU_HALT && st_q.ws_status) [*2];
    endproperty
    a_wake_halt: assert property (p_wake_halt)
        else $error("halt command did not leave wait or stop");

    property p_ws_fail;
        mem_bad |=> MEM_FAIL && !MEM_GRANT && wsf_q;
    endproperty
    a_ws_fail: assert property (p_ws_fail)
        else $error("colliding access not reported");

    property p_dvf_zero;
        RSP_VALID && $past(c_status) |-> !RSP_DATA[`SDB_BIT_DV_FAILURE];
    endproperty
    a_dvf_zero: assert property (p_dvf_zero)
        else $error("data valid failure reported");

    property p_halted_enable;
        c_control && CPU_HALT |=> $stable(st_q.bg_enable) && CPU_HALT;
    endproperty
    a_halted_enable: assert property (p_halted_enable)
        else $error("enable changed while halted");

    property p_store_back;
        c_control |=> COMM_CLK_SEL == $past(CMD_DATA[`SDB_BIT_CLK_SEL])
            && st_q.bkpt_en == $past(CMD_DATA[`SDB_BIT_BKPT_EN]);
    endproperty
    a_store_back: assert property (p_store_back)
        else $error("stored control bits not held");

endmodule

`default_nettype wire

// ===== src/sdb_params.svh
`ifndef SDB_PARAMS_SVH
`define SDB_PARAMS_SVH

// bit positions inside the debug status/control byte
`define SDB_BIT_BG_ENABLE   7
`define SDB_BIT_BG_ACTIVE   6
`define SDB_BIT_BKPT_EN     5
`define SDB_BIT_FORCE_SEL   4
`define SDB_BIT_CLK_SEL     3
`define SDB_BIT_WS_STATUS   2
`define SDB_BIT_WS_FAILURE  1
`define SDB_BIT_DV_FAILURE  0

// decoded serial debug command codes
`define SDB_CMD_NONE        3'h0
`define SDB_CMD_STATUS      3'h1
`define SDB_CMD_CONTROL     3'h2
`define SDB_CMD_MFETCH      3'h3
`define SDB_CMD_MLOAD       3'h4
`define SDB_CMD_HALT        3'h5
`define SDB_CMD_RESUME      3'h6
`define SDB_CMD_MEMACC      3'h7

// reset values
`define SDB_CTL_RESET       1'b0
`define SDB_ADDR_RESET      16'h0000
`define SDB_RSP_RESET       16'h0000

`endif

// ===== src/sdb_pkg.sv
package sdb_pkg;

    // 16-bit address or answer word
    typedef logic [15:0] sdb_word_type;
    // decoded command code
    typedef logic [2:0]  sdb_cmd_type;

    // cpu mode as seen by the debug controller
    typedef enum logic {
        SDB_RUN,
        SDB_HALTED
    } sdb_mode_type;

    // whole state of the status/control top
    typedef struct packed {
        sdb_mode_type mode;
        logic         bg_active;
        logic         bg_enable;
        logic         bkpt_en;
        logic         force_sel;
        logic         clk_sel;
        logic         ws_latch;
        logic         ws_status;
        logic         rsp_valid;
        sdb_word_type rsp_data;
        logic         mem_grant;
        logic         mem_fail;
        logic         soft_req;
    } sdb_ctrl_state_type;

    // breakpoint register and registered hits
    typedef struct packed {
        sdb_word_type match_addr;
        logic         tag_hit;
        logic         force_hit;
    } sdb_bkpt_state_type;

    // one sticky flag
    typedef struct packed {
        logic q;
    } sdb_flag_state_type;

endpackage

// ===== src/sdb_flag.sv
`timescale 1ns/1ns
`default_nettype none

module sdb_flag (
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // set and clear events
    input  wire logic set,
    input  wire logic clr,
    // flag value
    output logic      q
);
    import sdb_pkg::*;

    sdb_flag_state_type st_q;   // registered flag
    sdb_flag_state_type st_d;   // next flag

    // set beats clear so an event in the clearing cycle survives
    always_comb begin
        st_d = st_q;
        if (set) begin
            st_d.q = 1'b1;
        end else if (clr) begin
            st_d.q = 1'b0;
        end
    end

    // synchronous active-low reset
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.q;

endmodule

`default_nettype wire

// ===== src/sdb_bkpt.sv
`timescale 1ns/1ns
`default_nettype none
`include "sdb_params.svh"

module sdb_bkpt (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    // match load from the serial side
    input  wire logic         load,
    input  wire logic [15:0]  load_data,
    // cpu bus
    input  wire logic [15:0]  addr,
    input  wire logic         bus_valid,
    input  wire logic         op_fetch,
    // qualifiers from the control byte
    input  wire logic         tag_en,
    input  wire logic         force_en,
    // results
    output logic [15:0]       match_addr,
    output logic              tag_hit,
    output logic              force_hit
);
    import sdb_pkg::*;

    sdb_bkpt_state_type st_q;   // registered state
    sdb_bkpt_state_type st_d;   // next state
    logic               hit;    // compare against stored address

    // compare uses the stored value, a load lands one cycle later
    always_comb begin
        st_d = st_q;
        hit = (addr == st_q.match_addr);
        if (load) begin
            st_d.match_addr = load_data;
        end
        // tag only on opcode fetches
        st_d.tag_hit = tag_en && op_fetch && hit;
        // force on any valid bus cycle, opcode or not
        st_d.force_hit = force_en && bus_valid && hit;
    end

    // synchronous active-low reset
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_q.match_addr <= `SDB_ADDR_RESET;
            st_q.tag_hit    <= 1'b0;
            st_q.force_hit  <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign match_addr = st_q.match_addr;
    assign tag_hit    = st_q.tag_hit;
    assign force_hit  = st_q.force_hit;

endmodule

`default_nettype wire

// ===== tb/sdb_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module sdb_host_model (
    // clock
    input  wire logic                  clk,
    // command side toward the controller
    output var  logic                  cmd_valid,
    output var  sdb_pkg::sdb_cmd_type  cmd_code,
    output var  sdb_pkg::sdb_word_type cmd_data,
    // answers from the controller
    input  wire logic                  rsp_valid,
    input  wire sdb_pkg::sdb_word_type rsp_data
);
    import sdb_pkg::*;

    // idle until the bench asks for a command
    initial begin
        cmd_valid = 1'b0;
        cmd_code  = 3'h0;
        cmd_data  = 16'h0000;
    end

    // one command, raised after a falling edge and held one whole cycle
    task automatic send(input sdb_cmd_type code, input sdb_word_type data);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_code  = code;
        cmd_data  = data;
        @(negedge clk);
        cmd_valid = 1'b0;
        // released lines show garbage, never the last word
        cmd_code  = ~code;
        cmd_data  = ~data;
    endtask

    // command with an answer; bounded wait so a lost answer cannot hang
    task automatic ask(input sdb_cmd_type code, output sdb_word_type word, output bit ok);
        int n;
        send(code, 16'h0000);
        ok   = 1'b0;
        word = 16'h0000;
        // the answer already stands at the release edge of send, look first
        for (n = 0; n < 4 && !ok; n++) begin
            if (rsp_valid === 1'b1) begin
                ok   = 1'b1;
                word = rsp_data;
            end else begin
                @(negedge clk);
            end
        end
    endtask
endmodule

`default_nettype wire

// ===== tb/sdb_status_ctrl_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "sdb_params.svh"

module sdb_status_ctrl_test;
    import sdb_pkg::*;

    logic         CLK, RESETN;                    // clock and reset
    logic         CMD_VALID, RSP_VALID;           // command handshake
    sdb_cmd_type  CMD_CODE;                       // command code
    sdb_word_type CMD_DATA, RSP_DATA, CPU_ADDR;   // words
    logic         MEM_GRANT, MEM_FAIL;            // memory access answers
    logic         CPU_BUS_VALID, CPU_OPFETCH;     // cpu bus qualifiers
    logic         CPU_BOUNDARY, CPU_TAG_AT_END;   // cpu pipeline events
    logic         CPU_WAIT_STOP, CPU_WS_EXEC;     // low power state
    logic         CPU_HALT, TAG_MARK;             // breakpoint results
    logic         SOFT_INT_REQ, COMM_CLK_SEL;     // refused break, link clock
    int           miscompares, samples_checked;   // verdict counters

    sdb_status_ctrl uut (.CLK(CLK), .RESETN(RESETN), .CMD_VALID(CMD_VALID),
        .CMD_CODE(CMD_CODE), .CMD_DATA(CMD_DATA), .RSP_VALID(RSP_VALID),
        .RSP_DATA(RSP_DATA), .MEM_GRANT(MEM_GRANT), .MEM_FAIL(MEM_FAIL),
        .CPU_ADDR(CPU_ADDR), .CPU_BUS_VALID(CPU_BUS_VALID), .CPU_OPFETCH(CPU_OPFETCH),
        .CPU_BOUNDARY(CPU_BOUNDARY), .CPU_TAG_AT_END(CPU_TAG_AT_END),
        .CPU_WAIT_STOP(CPU_WAIT_STOP), .CPU_WS_EXEC(CPU_WS_EXEC), .CPU_HALT(CPU_HALT),
        .TAG_MARK(TAG_MARK), .SOFT_INT_REQ(SOFT_INT_REQ), .COMM_CLK_SEL(COMM_CLK_SEL));

    sdb_host_model host (.clk(CLK), .cmd_valid(CMD_VALID), .cmd_code(CMD_CODE),
        .cmd_data(CMD_DATA), .rsp_valid(RSP_VALID), .rsp_data(RSP_DATA));

    // 25 mhz clock
    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end

    // verdict, the single exit of the run
    task automatic close_out;
        if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // word compare
    task automatic chk(input sdb_word_type got, input sdb_word_type exp);
        samples_checked++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask

    // single bit compare
    task automatic chk1(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask

    // answered command; a missing answer ends the run
    task automatic ask(input sdb_cmd_type code, input sdb_word_type exp);
        sdb_word_type w;
        bit           ok;
        host.ask(code, w, ok);
        if (!ok) begin
            miscompares++;
            close_out();
        end
        chk(w, exp);
    endtask

    // control store of one byte
    task automatic store(input logic [7:0] b);
        host.send(`SDB_CMD_CONTROL, {8'h00, b});
    endtask

    // memory access command and its one-cycle answer
    task automatic mem(input logic grant, input logic fail);
        host.send(`SDB_CMD_MEMACC, 16'h0000);
        chk1(MEM_GRANT, grant);
        chk1(MEM_FAIL, fail);
    endtask

    // one cpu bus cycle; the address floats to garbage afterwards
    task automatic cpu_cycle(input sdb_word_type a, input logic fetch);
        @(negedge CLK);
        CPU_ADDR      = a;
        CPU_BUS_VALID = 1'b1;
        CPU_OPFETCH   = fetch;
        @(negedge CLK);
        CPU_BUS_VALID = 1'b0;
        CPU_OPFETCH   = 1'b0;
        CPU_ADDR      = ~a;
    endtask

    // one-cycle pipeline event pulses
    task automatic cpu_pulse(input logic bnd, input logic tend);
        @(negedge CLK);
        CPU_BOUNDARY   = bnd;
        CPU_TAG_AT_END = tend;
        @(negedge CLK);
        CPU_BOUNDARY   = 1'b0;
        CPU_TAG_AT_END = 1'b0;
    endtask

    // collect halt, tag and soft request over a short fixed window
    task automatic watch(input logic eh, input logic et, input logic es);
        logic h, t, s;
        h = 1'b0;
        t = 1'b0;
        s = 1'b0;
        // first look at the current edge, the pulse may already stand
        repeat (4) begin
            h = h | CPU_HALT;
            t = t | TAG_MARK;
            s = s | SOFT_INT_REQ;
            @(negedge CLK);
        end
        chk({13'h0000, h, t, s}, {13'h0000, eh, et, es});
    endtask

    // reset values of both registers and the link clock select
    task automatic t_reset;
        chk1(COMM_CLK_SEL, 1'b0);
        ask(`SDB_CMD_STATUS, 16'h0000);
        ask(`SDB_CMD_MFETCH, 16'h0000);
    endtask

    // halt and breakpoint refused while background is not enabled
    task automatic t_refused;
        store(8'h30);
        host.send(`SDB_CMD_MLOAD, 16'h1234);
        ask(`SDB_CMD_MFETCH, 16'h1234);
        host.send(`SDB_CMD_HALT, 16'h0000);
        chk1(CPU_HALT, 1'b0);
        ask(`SDB_CMD_STATUS, 16'h0030);
        mem(1'b1, 1'b0);
        CPU_WS_EXEC = 1'b1;
        mem(1'b0, 1'b1);
        CPU_WS_EXEC = 1'b0;
        ask(`SDB_CMD_STATUS, 16'h0032);
        mem(1'b1, 1'b0);
        cpu_cycle(16'h1234, 1'b0);
        cpu_pulse(1'b1, 1'b0);
        watch(1'b0, 1'b0, 1'b1);
    endtask

    // store cannot touch status bits, and the enable only rises
    task automatic t_store;
        store(8'hff);
        ask(`SDB_CMD_STATUS, 16'h00b8);
        chk1(COMM_CLK_SEL, 1'b1);
        store(8'h00);
        ask(`SDB_CMD_STATUS, 16'h0080);
        chk1(COMM_CLK_SEL, 1'b0);
    endtask

    // halted mode with the clock select still writable
    task automatic t_halt;
        host.send(`SDB_CMD_HALT, 16'h0000);
        chk1(CPU_HALT, 1'b1);
        ask(`SDB_CMD_STATUS, 16'h00c0);
        store(8'h08);
        ask(`SDB_CMD_STATUS, 16'h00c8);
        host.send(`SDB_CMD_RESUME, 16'h0000);
        chk1(CPU_HALT, 1'b0);
        store(8'h00);
        ask(`SDB_CMD_STATUS, 16'h0080);
    endtask

    // wait/stop status, failed access and the recovery sequence
    task automatic t_wait;
        @(negedge CLK);
        CPU_WAIT_STOP = 1'b1;
        ask(`SDB_CMD_STATUS, 16'h0084);
        mem(1'b0, 1'b1);
        ask(`SDB_CMD_STATUS, 16'h0086);
        host.send(`SDB_CMD_HALT, 16'h0000);
        CPU_WAIT_STOP = 1'b0;
        chk1(CPU_HALT, 1'b1);
        ask(`SDB_CMD_STATUS, 16'h00c6);
        mem(1'b1, 1'b0);
        ask(`SDB_CMD_STATUS, 16'h00c4);
        host.send(`SDB_CMD_RESUME, 16'h0000);
        ask(`SDB_CMD_STATUS, 16'h0080);
    endtask

    // force match waits for the instruction boundary
    task automatic t_force;
        store(8'hb0);
        cpu_cycle(16'h1234, 1'b0);
        watch(1'b0, 1'b0, 1'b0);
        cpu_pulse(1'b1, 1'b0);
        watch(1'b1, 1'b0, 1'b0);
        host.send(`SDB_CMD_RESUME, 16'h0000);
    endtask

    // tagged opcode halts only when it reaches the queue end
    task automatic t_tag;
        store(8'ha0);
        cpu_cycle(16'h1234, 1'b1);
        watch(1'b0, 1'b1, 1'b0);
        cpu_pulse(1'b0, 1'b1);
        watch(1'b1, 1'b0, 1'b0);
        host.send(`SDB_CMD_RESUME, 16'h0000);
    endtask

    // breakpoint disabled: match, boundary and queue end all ignored
    task automatic t_off;
        store(8'h90);
        cpu_cycle(16'h1234, 1'b1);
        cpu_pulse(1'b1, 1'b1);
        watch(1'b0, 1'b0, 1'b0);
    endtask

    // main sequence
    initial begin
        miscompares     = 0;
        samples_checked = 0;
        RESETN          = 1'b0;
        CPU_ADDR        = 16'h0000;
        CPU_BUS_VALID   = 1'b0;
        CPU_OPFETCH     = 1'b0;
        CPU_BOUNDARY    = 1'b0;
        CPU_TAG_AT_END  = 1'b0;
        CPU_WAIT_STOP   = 1'b0;
        CPU_WS_EXEC     = 1'b0;
        repeat (2) @(negedge CLK);
        RESETN = 1'b1;
        t_reset();
        t_refused();
        t_store();
        t_halt();
        t_wait();
        t_force();
        t_tag();
        t_off();
        close_out();
    end
endmodule

`default_nettype wire
